// ### shared/cid_pkg.sv
// Constants and carrier types of the contact-input debouncer.
// Assumes a 20 MHz clock and a classic Wishbone register port.
// Function
// (R1) Sample every contact input together once per 0.5 ms scan.
// (R2) A raw sample reads closed when voltage is at or above threshold.
// (R3) Accept a new state after the settle interval; 2.5 ms confirms on sample six.
// (R4) A validated change updates the debounced flag and may record an event.
// (R5) Timestamp a change with the time of the first agreeing sample.
// (R6) With logging enabled, every validated change in both directions makes an event.
// (R7) Run the protection pass eight times per cycle; pass length set by tracking; the code takes it from the A_PASS register.
// (R8) Copy validated states to the logic operands only at a pass start.
// (R9) Operand delay is settle interval plus zero to one protection pass.
// (R10) Timestamps carry one microsecond resolution for any settle interval.
// (R11) Rising and falling transitions use the same procedure and interval.
// (R12) Give a closed flag and a complementary open flag per input.
// (R13) One threshold per group of four inputs, shared by the group.
// (R14) A disagreeing sample discards the candidate; old state and stamp stay.
package cid_pkg;
   localparam int CLK_MHZ = 20;
   localparam int SCAN_NS = 500_000;
   localparam int SCAN_CYC = SCAN_NS * CLK_MHZ / 1000;
   localparam int US_CYC = CLK_MHZ;
   localparam int SCAN_US = SCAN_NS / 1000;
   localparam int SETTLE_US = 2500;
   localparam logic [7:0] SETTLE_RST = 8'(SETTLE_US / SCAN_US);
   localparam int PASS_US = 2083;
   localparam logic [23:0] PASS_RST = 24'(PASS_US * CLK_MHZ);
   localparam int GROUP = 4;
   localparam logic [7:0] A_SETTLE = 8'h00;
   localparam logic [7:0] A_PASS = 8'h04;
   localparam logic [7:0] A_STATE = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0c;
   localparam logic [7:0] A_MASK = 8'h10;
   localparam logic [7:0] A_EVEN = 8'h14;
   localparam logic [7:0] A_TIME = 8'h18;
   localparam logic [7:0] A_THR = 8'h20;
   localparam logic [7:0] A_STAMP = 8'h80;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } cid_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } cid_wb_rsp_t;
endpackage

// ### src/cid_top.sv
// Contact-input debouncer with scan timer, pass scheduler and timestamps.
// Assumes digitised input voltages synchronous to clk_i and a Wishbone
// master that holds each request until ack.
`timescale 1ns/1ps
`default_nettype none
module cid_top #(
   parameter int N = 8,
   parameter int VW = 10,
   parameter int SCAN = cid_pkg::SCAN_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [N-1:0][VW-1:0] volt_i,
   input wire cid_pkg::cid_wb_req_t wb_i,
   output cid_pkg::cid_wb_rsp_t wb_o,
   output logic [N-1:0] input_closed_flag_o,
   output logic [N-1:0] input_open_flag_o,
   output logic [N-1:0] event_o,
   output logic pass_start_o,
   output logic irq_o
);
   import cid_pkg::*;

   localparam int G = N / GROUP;

   // Refuse sizes the register map and counters cannot serve
   if (N < GROUP || N > 24 || N % GROUP != 0) begin : g_bad_n
      $error("cid_top: N must be 4..24 in steps of four");
   end
   if (VW < 1 || VW > 32) begin : g_bad_vw
      $error("cid_top: VW out of range");
   end
   if (SCAN < 2 || SCAN > 65535) begin : g_bad_scan
      $error("cid_top: SCAN out of range");
   end

   typedef struct packed {
      logic [N-1:0] oper;
      logic [N-1:0] openf;
      logic [N-1:0] valid;
      logic [N-1:0] prev;
      logic [N-1:0][7:0] run;
      logic [N-1:0][31:0] cst;
      logic [N-1:0][31:0] stamp;
      logic [N-1:0] stat;
      logic [N-1:0] mask;
      logic [N-1:0] even;
      logic [N-1:0] evt;
      logic [G-1:0][VW-1:0] thr;
      logic [7:0] settle;
      logic [23:0] pass_per;
      logic [23:0] pass_cnt;
      logic pass;
      logic [15:0] scan_cnt;
      logic [4:0] pre;
      logic [31:0] usec;
      logic ack;
      logic [31:0] dat;
      logic irq;
   } cid_state_t;

   cid_state_t q;
   cid_state_t next_q;

   logic [31:0] wmask;
   logic rd_ev;
   logic wr_ev;
   logic samp;
   logic raw;
   logic [N-1:0] set_ev;
   logic [7:0] idx;

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wmask[b*8 +: 8] = {8{wb_i.sel[b]}};
      end
   end

   always_comb begin
      next_q = q;
      raw = 1'b0;
      idx = 8'h00;
      set_ev = '0;
      rd_ev = wb_i.cyc && wb_i.stb && !q.ack && !wb_i.we;
      wr_ev = wb_i.cyc && wb_i.stb && !q.ack && wb_i.we;

      // Free-running microsecond time base for stamps [R10]
      if (q.pre == 5'(US_CYC - 1)) begin
         next_q.pre = '0;
         next_q.usec = q.usec + 32'h0000_0001;
      end else begin
         next_q.pre = q.pre + 5'h01;
      end

      // Common scan instant for all inputs [R1]
      samp = (q.scan_cnt == 16'(SCAN - 1));
      next_q.scan_cnt = samp ? '0 : q.scan_cnt + 16'h0001;

      // Protection pass scheduler, period from the A_PASS register [R7]
      next_q.pass = 1'b0;
      if (q.pass_cnt + 24'h00_0001 >= q.pass_per) begin
         next_q.pass_cnt = '0;
         next_q.pass = 1'b1;
      end else begin
         next_q.pass_cnt = q.pass_cnt + 24'h00_0001;
      end

      next_q.evt = '0;
      for (int i = 0; i < N; i++) begin
         if (samp) begin
            // Group threshold compare [R2] [R13]
            raw = volt_i[i] >= q.thr[i / GROUP];
            next_q.prev[i] = raw;
            if (raw == q.valid[i]) begin
               next_q.run[i] = '0; // [R14]
            end else begin
               // Same path for either direction [R11]
               if (q.run[i] == 8'h00 || raw != q.prev[i]) begin
                  next_q.run[i] = 8'h01;
                  next_q.cst[i] = q.usec; // [R5]
               end else begin
                  next_q.run[i] = q.run[i] + 8'h01;
               end
               if (q.run[i] != 8'h00 && raw == q.prev[i] &&
                   q.run[i] >= q.settle) begin
                  // Confirmed on sample settle+1 [R3] [R4]
                  next_q.valid[i] = raw;
                  next_q.run[i] = '0;
                  next_q.stamp[i] = q.cst[i]; // [R5]
                  set_ev[i] = q.even[i]; // [R6]
               end else if (q.settle == 8'h00 && q.run[i] == 8'h00) begin
                  next_q.valid[i] = raw; // [R3]
                  next_q.run[i] = '0;
                  next_q.stamp[i] = q.usec;
                  set_ev[i] = q.even[i]; // [R6]
               end
            end
         end
      end
      next_q.evt = set_ev;

      // Operands change only at pass start [R8] [R9] [R12]
      if (q.pass) begin
         next_q.oper = q.valid;
         next_q.openf = ~q.valid;
      end

      // Bus slave, one wait state
      next_q.ack = wb_i.cyc && wb_i.stb && !q.ack;
      next_q.dat = '0;
      if (rd_ev) begin
         unique case (wb_i.adr)
            A_SETTLE: next_q.dat = 32'(q.settle);
            A_PASS: next_q.dat = 32'(q.pass_per);
            A_STATE: next_q.dat = 32'(q.oper);
            A_STAT: next_q.dat = 32'(q.stat);
            A_MASK: next_q.dat = 32'(q.mask);
            A_EVEN: next_q.dat = 32'(q.even);
            A_TIME: next_q.dat = q.usec;
            default: begin
               if (wb_i.adr >= A_THR &&
                   wb_i.adr < A_THR + 8'(4 * G)) begin
                  idx = 8'((wb_i.adr - A_THR) >> 2);
                  next_q.dat = 32'(q.thr[idx]);
               end else if (wb_i.adr >= A_STAMP &&
                            wb_i.adr < A_STAMP + 8'(4 * N)) begin
                  idx = 8'((wb_i.adr - A_STAMP) >> 2);
                  next_q.dat = q.stamp[idx];
               end
            end
         endcase
      end
      if (wr_ev) begin
         unique case (wb_i.adr)
            A_SETTLE: next_q.settle =
               8'((32'(q.settle) & ~wmask) | (wb_i.dat & wmask));
            A_PASS: next_q.pass_per =
               24'((32'(q.pass_per) & ~wmask) | (wb_i.dat & wmask));
            A_MASK: next_q.mask =
               N'((32'(q.mask) & ~wmask) | (wb_i.dat & wmask));
            A_EVEN: next_q.even =
               N'((32'(q.even) & ~wmask) | (wb_i.dat & wmask));
            default: begin
               if (wb_i.adr >= A_THR &&
                   wb_i.adr < A_THR + 8'(4 * G)) begin
                  idx = 8'((wb_i.adr - A_THR) >> 2);
                  next_q.thr[idx] = VW'((32'(q.thr[idx]) & ~wmask) |
                                        (wb_i.dat & wmask));
               end
            end
         endcase
      end

      // Sticky events, cleared by read; a new event wins
      if (rd_ev && wb_i.adr == A_STAT)
         next_q.stat = set_ev;
      else
         next_q.stat = q.stat | set_ev;
      next_q.irq = |(next_q.stat & q.mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.openf <= '1;
         q.settle <= SETTLE_RST;
         q.pass_per <= PASS_RST;
      end else begin
         q <= next_q;
      end
   end

   assign wb_o.ack = q.ack;
   assign wb_o.dat = q.dat;
   assign input_closed_flag_o = q.oper;
   assign input_open_flag_o = q.openf;
   assign event_o = q.evt;
   assign pass_start_o = q.pass;
   assign irq_o = q.irq;
endmodule
`default_nettype wire

// ### dv/cid_field.sv
// Field contacts, wetted from one source voltage per group of four.
// Assumes the bench opens and closes contacts off the sampling edge.
`timescale 1ns/1ps
`default_nettype none
module cid_field #(parameter int N = 8, parameter int VW = 10) (
   input wire logic [N-1:0] close_i,
   input wire logic [N/4-1:0][VW-1:0] wet_i,
   output logic [N-1:0][VW-1:0] volt_o
);
   always_comb begin
      for (int i = 0; i < N; i++) begin
         volt_o[i] = close_i[i] ? wet_i[i/4] : '0;
      end
   end
endmodule
`default_nettype wire

// ### dv/cid_monitor.sv
// Port checker for cid_top.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cid_monitor #(parameter int N = 8, parameter int VW = 10) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire cid_pkg::cid_wb_req_t wb_i,
   input wire cid_pkg::cid_wb_rsp_t wb_o,
   input wire logic [N-1:0] input_closed_flag_o,
   input wire logic [N-1:0] input_open_flag_o,
   input wire logic [N-1:0] event_o,
   input wire logic pass_start_o,
   input wire logic irq_o
);
   import cid_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (wb_o.ack |=> !wb_o.ack)
      else $error("ack longer than one cycle");
   a_ack_answer: assert property
      (wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack)
      else $error("request not answered next cycle");
   a_dat_idle: assert property (!wb_o.ack |-> wb_o.dat == '0)
      else $error("read data without ack");
   a_open_comp: assert property
      (input_open_flag_o == ~input_closed_flag_o)
      else $error("open flag not complement");
   a_flag_at_pass: assert property
      ($changed(input_closed_flag_o) |-> $past(pass_start_o))
      else $error("operand changed outside pass start");
   a_pass_pulse: assert property (pass_start_o |=> !pass_start_o)
      else $error("pass start longer than one cycle");
   a_event_pulse: assert property (|event_o |=> event_o == '0)
      else $error("event longer than one cycle");
   a_reset_idle: assert property (disable iff (1'b0)
      rst_i |=> !irq_o && input_closed_flag_o == '0 && !pass_start_o)
      else $error("outputs not idle in reset");
endmodule
bind cid_top cid_monitor #(.N(N), .VW(VW)) mon (.clk_i(clk_i),
   .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .event_o(event_o),
   .input_closed_flag_o(input_closed_flag_o), .irq_o(irq_o),
   .input_open_flag_o(input_open_flag_o), .pass_start_o(pass_start_o));
`default_nettype wire

// ### dv/contact_input_debouncer_tb.sv
// Self-checking bench for the contact-input debouncer.
// Assumes SCAN set to 20 clocks, so one scan lasts one microsecond.
`timescale 1ns/1ps
`default_nettype none
module contact_input_debouncer_tb;
   import cid_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] close = 8'h11;
   logic [7:0][9:0] volt;
   logic [7:0] cl, op, ev;
   logic ps, irq;
   cid_wb_req_t wb_i = '0;
   cid_wb_rsp_t wb_o;
   logic [31:0] rd, s0;
   int num_errors = 0;
   int num_checks = 0;
   int cyc_n = 0;
   int e0, x1, n;
   cid_field #(.N(8), .VW(10)) fld (.close_i(close),
      .wet_i({10'h096, 10'h064}), .volt_o(volt));
   cid_top #(.N(8), .VW(10), .SCAN(20)) uut (.clk_i(clk_i), .rst_i(rst_i),
      .volt_i(volt), .wb_i(wb_i), .wb_o(wb_o), .input_closed_flag_o(cl),
      .input_open_flag_o(op), .event_o(ev), .pass_start_o(ps), .irq_o(irq));
   initial forever #25 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 3000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
      wb_i <= '{1'b1, 1'b1, we, 4'hf, a, d};
      @(posedge clk_i);
      while (wb_o.ack !== 1'b1) @(posedge clk_i);
      rd = wb_o.dat;
      wb_i <= '0;
      @(posedge clk_i);
   endtask
   // Steps to a fixed phase eleven clocks before a scan
   task automatic sync();
      while ((cyc_n - e0) % 20 != 8) @(posedge clk_i);
   endtask
   task automatic t_init();
      wb(1'b0, A_SETTLE, '0);
      chk("settle", 32'h0000_0005, rd);
      wb(1'b1, A_THR, 32'h0000_0064);
      wb(1'b1, A_THR + 8'h04, 32'h0000_0097);
      wb(1'b1, A_PASS, 32'h0000_0032);
      wb(1'b1, A_EVEN, 32'h0000_00ff);
      wb(1'b1, A_MASK, 32'h0000_00ff);
      while (ev === 8'h00) @(posedge clk_i);
      e0 = cyc_n;
      chk("first event", 8'h01, ev);
      repeat (60) @(posedge clk_i);
      chk("closed", 8'h01, cl);
      chk("open", 8'hfe, op);
      chk("irq", 1'b1, irq);
      wb(1'b0, A_STAT, '0);
      chk("status", 8'h01, rd);
      @(posedge clk_i);
      chk("irq", 1'b0, irq);
      $display("test init done");
   endtask
   // Five agreeing scans, one short of the sixth that confirms a change
   task automatic t_glitch();
      sync();
      n = 0;
      for (int i = 0; i < 140; i++) begin
         close[1] <= (i < 100);
         @(posedge clk_i);
         if (ev !== 8'h00) n++;
      end
      chk("glitch events", 0, n);
      $display("test glitch done");
   endtask
   task automatic t_step(logic lvl, logic [7:0] ecl, logic eirq);
      sync();
      x1 = cyc_n;
      close[1] <= lvl;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ev === 8'h00 && n < 200);
      chk("settle delay", 112, n);
      chk("event", 8'h02, ev);
      repeat (53) @(posedge clk_i);
      chk("operand", ecl, cl);
      chk("irq", eirq, irq);
      wb(1'b0, A_STAT, '0);
      chk("status", 8'h02, rd);
      wb(1'b0, A_STAMP, '0);
      s0 = rd;
      wb(1'b0, A_STAMP + 8'h04, '0);
      chk("stamp", (x1 - e0 + 112) / 20, rd - s0);
      $display("test step done");
   endtask
   task automatic t_regs();
      wb(1'b1, A_STATE, 32'h0000_00ff);
      wb(1'b0, A_STATE, '0);
      chk("state read only", 8'h01, rd);
      wb(1'b0, 8'h40, '0);
      chk("unmapped", '0, rd);
      $display("test regs done");
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_init();
      t_glitch();
      t_step(1'b1, 8'h03, 1'b1);
      wb(1'b1, A_MASK, '0);
      t_step(1'b0, 8'h01, 1'b0);
      t_regs();
      test_done();
   end
endmodule
`default_nettype wire
